// File: design/ilo_add_alu.sv
// Eight-bit adder with the five arithmetic status flags.
`timescale 1ns/1ps
module ilo_add_alu (
  input  wire logic               [7:0] acc_i,
  input  wire logic               [7:0] opnd_i,
  output logic                    [7:0] sum_o,
  output ilo_pkg::ilo_flags_s           flags_o
);
  import ilo_pkg::*;

  logic [8:0] full; // Sum with carry out.
  logic [4:0] low;  // Low nibble sum with its carry.

  // Signed overflow shows when both inputs share a sign the sum lacks.
  always_comb begin
    full       = {1'b0, acc_i} + {1'b0, opnd_i};
    low        = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
    sum_o      = full[7:0];
    flags_o.c  = full[8];
    flags_o.dc = low[4];
    flags_o.z  = (full[7:0] == 8'h00);
    flags_o.n  = full[7];
    flags_o.ov = (acc_i[7] == opnd_i[7]) && (full[7] != acc_i[7]);
  end
endmodule

// File: design/ilo_data_ram.sv
// Byte-wide data memory with a registered read port.
`timescale 1ns/1ps
module ilo_data_ram #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);
  // The array itself has no reset; software must write before it reads.
  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;

  // Read data follow the address one edge later.
  always_comb begin
    rdata_next = mem_q[addr_i];
  end

  // Write port and read register.
  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o = rdata_reg;
endmodule

// File: design/ilo_indexed_decode.sv
// Operand decode and four-cycle execution with indexed literal offsets.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Function
// RULE1 - Small file field adds to stack frame pointer.
// RULE2 - Indexing only when bank-select bit is clear.
// RULE3 - Destination bit: clear accumulator, set file.
// RULE4 - Indexed add sums accumulator and operand, flags.
// RULE5 - Extension off: access bank or banked literal.
// RULE6 - Add runs decode, read, compute, write phases.
module ilo_indexed_decode #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);
  import ilo_pkg::*;

  // Work out where an opcode's file operand lives.
  function automatic ilo_decode_s ilo_decode(
    input logic [15:0] op,
    input logic        ext,
    input logic [11:0] sfp,
    input logic [3:0]  bank_select_register
  );
    ilo_decode_s d;
    d.is_add  = (op[15:10] == ILO_OPC_ADD);
    d.dest    = op[9];
    d.indexed = 1'b0;
    // RULE2 - bank bit gates indexing.
    if (!op[8] && ext && (op[7:0] <= ILO_IDX_MAX)) begin
      // RULE1 - offset from pointer.
      d.indexed = 1'b1;
      d.ea      = sfp + {4'h0, op[7:0]};
    end else if (!op[8]) begin
      // RULE5 - access bank literal.
      d.ea = (op[7:0] <= ILO_IDX_MAX) ? {4'h0, op[7:0]} : {ILO_ACC_HI_BNK, op[7:0]};
    end else begin
      // RULE5 - banked literal address.
      d.ea = {bank_select_register, op[7:0]};
    end
    return d;
  endfunction

  // Bus data phase state.
  logic        pend_reg;
  logic        pend_next;
  logic        pwr_reg;
  logic        pwr_next;
  logic [7:0]  pofs_reg;
  logic [7:0]  pofs_next;
  logic        rdy_reg;
  logic        rdy_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic        resp_reg;

  // Core state.
  ilo_phase_e  phase_reg;
  ilo_phase_e  phase_next;
  logic        ext_reg;
  logic        ext_next;
  logic [7:0]  acc_reg;
  logic [7:0]  acc_next;
  logic [11:0] sfp_reg;
  logic [11:0] sfp_next;
  logic [3:0]  bsr_reg;
  logic [3:0]  bsr_next;
  logic [15:0] instr_reg;
  logic [15:0] instr_next;
  ilo_flags_s  flags_reg;
  ilo_flags_s  flags_next;
  ilo_flags_s  nflags_reg;       // Flags computed in the third phase.
  ilo_flags_s  nflags_next;
  logic [7:0]  res_reg;          // Sum computed in the third phase.
  logic [7:0]  res_next;
  ilo_decode_s dec_reg;
  ilo_decode_s dec_next;
  logic [11:0] maddr_reg;
  logic [11:0] maddr_next;

  // Shared wires.
  logic        addr_phase;       // Address phase taken this edge.
  logic        wr_fire;          // Write data phase finishing this edge.
  logic        idle;             // No instruction in flight.
  logic        mem_we;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  logic [7:0]  alu_sum;
  ilo_flags_s  alu_flags;
  logic [31:0] status_word;

  // Small leaf blocks.
  ilo_data_ram #(
    .ADDR_W (ADDR_W),
    .DATA_W (8)
  ) u_ram (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .we_i       (mem_we),
    .addr_i     (mem_addr[ADDR_W-1:0]),
    .wdata_i    (mem_wdata),
    .rdata_o    (mem_rdata)
  );

  ilo_add_alu u_alu (
    .acc_i   (acc_reg),
    .opnd_i  (mem_rdata),
    .sum_o   (alu_sum),
    .flags_o (alu_flags)
  );

  // Only nonsequential and sequential transfers matter; size is not checked.
  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign wr_fire    = pend_reg && pwr_reg;
  assign idle       = (phase_reg == ILO_IDLE);

  // Status word seen by software.
  always_comb begin
    status_word             = ILO_RST_WORD;
    status_word[ILO_ST_C]   = flags_reg.c;
    status_word[ILO_ST_DC]  = flags_reg.dc;
    status_word[ILO_ST_Z]   = flags_reg.z;
    status_word[ILO_ST_OV]  = flags_reg.ov;
    status_word[ILO_ST_N]   = flags_reg.n;
    status_word[ILO_ST_BSY] = !idle;
    status_word[ILO_ST_IDX] = dec_reg.indexed;
  end

  // Every transfer gets one wait state so that read data leave a flop.
  always_comb begin
    pend_next = pend_reg;
    pwr_next  = pwr_reg;
    pofs_next = pofs_reg;
    rdy_next  = rdy_reg;
    rdat_next = rdat_reg;
    if (addr_phase) begin
      pend_next = 1'b1;
      pwr_next  = hwrite_i;
      pofs_next = haddr_i[7:0];
      rdy_next  = 1'b0;
    end else if (pend_reg) begin
      pend_next = 1'b0;
      rdy_next  = 1'b1;
      rdat_next = ILO_RST_WORD;
      if (!pwr_reg) begin
        // Unmapped offsets read as zero with an OKAY answer.
        unique case (pofs_reg)
          ILO_OFS_CTRL:   rdat_next = {31'h0, ext_reg};
          ILO_OFS_ACC:    rdat_next = {24'h0, acc_reg};
          ILO_OFS_SFP:    rdat_next = {20'h0, sfp_reg};
          ILO_OFS_BSR:    rdat_next = {28'h0, bsr_reg};
          ILO_OFS_INSTR:  rdat_next = {16'h0, instr_reg};
          ILO_OFS_STATUS: rdat_next = status_word;
          ILO_OFS_EADDR:  rdat_next = {20'h0, dec_reg.ea};
          ILO_OFS_MADDR:  rdat_next = {20'h0, maddr_reg};
          ILO_OFS_MDATA:  rdat_next = {24'h0, mem_rdata};
          default:        rdat_next = ILO_RST_WORD;
        endcase
      end
    end
  end

  // Bus state registers.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      pend_reg <= 1'b0;
      pwr_reg  <= 1'b0;
      pofs_reg <= ILO_RST_BYTE;
      rdy_reg  <= 1'b1;
      rdat_reg <= ILO_RST_WORD;
      resp_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
      pwr_reg  <= pwr_next;
      pofs_reg <= pofs_next;
      rdy_reg  <= rdy_next;
      rdat_reg <= rdat_next;
      resp_reg <= 1'b0;
    end
  end

  // Memory port: the instruction owns it while busy, software otherwise.
  always_comb begin
    mem_addr  = idle ? maddr_reg : dec_reg.ea;
    mem_wdata = idle ? hwdata_i[7:0] : res_reg;
    mem_we    = 1'b0;
    if (idle) begin
      mem_we = wr_fire && (pofs_reg == ILO_OFS_MDATA);
    end else if ((phase_reg == ILO_Q4) && dec_reg.is_add) begin
      // RULE3 - set bit writes file.
      mem_we = dec_reg.dest;
    end
  end

  // Core next state: register writes when idle, then the four phases.
  // Writes that land while an instruction runs are dropped, which keeps
  // the operands stable for the whole instruction.
  always_comb begin
    phase_next  = phase_reg;
    ext_next    = ext_reg;
    acc_next    = acc_reg;
    sfp_next    = sfp_reg;
    bsr_next    = bsr_reg;
    instr_next  = instr_reg;
    flags_next  = flags_reg;
    nflags_next = nflags_reg;
    res_next    = res_reg;
    dec_next    = dec_reg;
    maddr_next  = maddr_reg;
    unique case (phase_reg)
      ILO_IDLE: begin
        if (wr_fire) begin
          unique case (pofs_reg)
            ILO_OFS_CTRL:  ext_next   = hwdata_i[0];
            ILO_OFS_ACC:   acc_next   = hwdata_i[7:0];
            ILO_OFS_SFP:   sfp_next   = hwdata_i[11:0];
            ILO_OFS_BSR:   bsr_next   = hwdata_i[3:0];
            ILO_OFS_MADDR: maddr_next = hwdata_i[11:0];
            ILO_OFS_INSTR: begin
              instr_next = hwdata_i[15:0];
              phase_next = ILO_Q1;
            end
            default: begin
              // Read-only and unmapped offsets ignore writes.
            end
          endcase
        end
      end
      ILO_Q1: begin
        // RULE6 - decode phase.
        dec_next   = ilo_decode(instr_reg, ext_reg, sfp_reg, bsr_reg);
        phase_next = ILO_Q2;
      end
      ILO_Q2: begin
        // RULE6 - operand read phase.
        phase_next = ILO_Q3;
      end
      ILO_Q3: begin
        // RULE4 - sum and flags.
        res_next    = alu_sum;
        nflags_next = alu_flags;
        phase_next  = ILO_Q4;
      end
      ILO_Q4: begin
        // RULE6 - write phase.
        if (dec_reg.is_add) begin
          flags_next = nflags_reg;
          // RULE3 - clear bit writes accumulator.
          if (!dec_reg.dest) begin
            acc_next = res_reg;
          end
        end
        phase_next = ILO_IDLE;
      end
      default: begin
        phase_next = ILO_IDLE;
      end
    endcase
  end

  // Core registers.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_reg  <= ILO_IDLE;
      ext_reg    <= 1'b0;
      acc_reg    <= ILO_RST_BYTE;
      sfp_reg    <= ILO_RST_ADDR;
      bsr_reg    <= 4'h0;
      instr_reg  <= ILO_RST_INSTR;
      flags_reg  <= '0;
      nflags_reg <= '0;
      res_reg    <= ILO_RST_BYTE;
      dec_reg    <= '0;
      maddr_reg  <= ILO_RST_ADDR;
    end else begin
      phase_reg  <= phase_next;
      ext_reg    <= ext_next;
      acc_reg    <= acc_next;
      sfp_reg    <= sfp_next;
      bsr_reg    <= bsr_next;
      instr_reg  <= instr_next;
      flags_reg  <= flags_next;
      nflags_reg <= nflags_next;
      res_reg    <= res_next;
      dec_reg    <= dec_next;
      maddr_reg  <= maddr_next;
    end
  end

  // Outputs come straight from flops.
  assign hrdata_o    = rdat_reg;
  assign hreadyout_o = rdy_reg;
  assign hresp_o     = resp_reg;
endmodule

// File: design/ilo_pkg.sv
// Shared constants, types and structs of the indexed literal offset decoder.
package ilo_pkg;

  // Register byte offsets on the bus, each one aligned 32-bit word.
  localparam logic [7:0] ILO_OFS_CTRL   = 8'h00; // Extension enable.
  localparam logic [7:0] ILO_OFS_ACC    = 8'h04; // Accumulator.
  localparam logic [7:0] ILO_OFS_SFP    = 8'h08; // Stack frame pointer.
  localparam logic [7:0] ILO_OFS_BSR    = 8'h0C; // Bank select register.
  localparam logic [7:0] ILO_OFS_INSTR  = 8'h10; // Opcode; a write executes it.
  localparam logic [7:0] ILO_OFS_STATUS = 8'h14; // Flags, busy, indexed.
  localparam logic [7:0] ILO_OFS_EADDR  = 8'h18; // Last effective address.
  localparam logic [7:0] ILO_OFS_MADDR  = 8'h1C; // Data memory window address.
  localparam logic [7:0] ILO_OFS_MDATA  = 8'h20; // Data memory window data.

  // Status field positions.
  localparam int unsigned ILO_ST_C   = 0;
  localparam int unsigned ILO_ST_DC  = 1;
  localparam int unsigned ILO_ST_Z   = 2;
  localparam int unsigned ILO_ST_OV  = 3;
  localparam int unsigned ILO_ST_N   = 4;
  localparam int unsigned ILO_ST_BSY = 8;
  localparam int unsigned ILO_ST_IDX = 9;

  // Decode constants.
  localparam logic [7:0] ILO_IDX_MAX    = 8'h5F; // Largest indexed offset.
  localparam logic [3:0] ILO_ACC_HI_BNK = 4'hF;  // Upper part of the access bank.
  localparam logic [5:0] ILO_OPC_ADD    = 6'h09; // Top six opcode bits of the add.

  // Reset values.
  localparam logic [7:0]  ILO_RST_BYTE  = 8'h00;
  localparam logic [11:0] ILO_RST_ADDR  = 12'h000;
  localparam logic [15:0] ILO_RST_INSTR = 16'h0000;
  localparam logic [31:0] ILO_RST_WORD  = 32'h0000_0000;

  // Instruction phases, one-hot.
  typedef enum logic [4:0] {
    ILO_IDLE = 5'h01,
    ILO_Q1   = 5'h02,
    ILO_Q2   = 5'h04,
    ILO_Q3   = 5'h08,
    ILO_Q4   = 5'h10
  } ilo_phase_e;

  // Arithmetic status flags.
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } ilo_flags_s;

  // Decoded operand of one instruction.
  typedef struct packed {
    logic        is_add;
    logic        dest;
    logic        indexed;
    logic [11:0] ea;
  } ilo_decode_s;

endpackage

// File: tb/ilo_checker.sv
// Bus timing and field width checker of the indexed literal offset decoder.
`timescale 1ns/1ps
module ilo_checker #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic        core_clk_i,
  input wire logic        rst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o
);
  import ilo_pkg::*;
  // An accepted address phase; reads of it are qualified by the offset below.
  logic taken;
  logic rd_tk;
  assign taken = hsel_i & htrans_i[1] & hready_i;
  assign rd_tk = taken & ~hwrite_i;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Every transfer gets exactly one wait cycle, so read data come from a flop.
  a_one_wait: assert property (taken |=> !hreadyout_o ##1 hreadyout_o)
    else $error("transfer did not take one wait cycle");
  // Ready is back up at the first edge after reset is let go.
  a_reset_ready: assert property ($rose(rst_n_i) |-> hreadyout_o)
    else $error("slave not ready after reset");
  a_resp_okay: assert property (hreadyout_o |-> !hresp_o)
    else $error("response not okay");
  // The accumulator is one byte wide, upper read bits stay clear.
  a_acc_byte: assert property (rd_tk && haddr_i[7:0] == ILO_OFS_ACC
    |=> ##1 hrdata_o[31:8] == '0)
    else $error("accumulator read has upper bits set");

  // Shadow of the operand registers, fed by completed bus writes, and the operand
  // address and indexed flag that the last opcode written calls for. Writes that
  // land while an instruction runs are not modelled, so a bench must not issue them.
  logic        wr_pend;  // A write address phase was taken at the last edge.
  logic [7:0]  wr_ofs;   // Offset of that write.
  logic        ext_sh;   // Extension enable as software set it.
  logic [11:0] sfp_sh;   // Stack frame pointer as software set it.
  logic [3:0]  bsr_sh;   // Bank select register as software set it.
  logic [11:0] ea_sh;    // Expected operand address of the last opcode.
  logic        idx_sh;   // Expected indexed flag of the last opcode.
  logic [7:0]  fld;      // File field of the opcode on the write data.
  assign fld = hwdata_i[7:0];

  // Write data stand in the cycle after the address phase, so they apply then.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
      ext_sh  <= 1'b0;
      sfp_sh  <= 12'h000;
      bsr_sh  <= 4'h0;
      ea_sh   <= 12'h000;
      idx_sh  <= 1'b0;
    end else begin
      wr_pend <= taken & hwrite_i;
      wr_ofs  <= haddr_i[7:0];
      if (wr_pend && wr_ofs == ILO_OFS_CTRL) begin
        ext_sh <= hwdata_i[0];
      end
      if (wr_pend && wr_ofs == ILO_OFS_SFP) begin
        sfp_sh <= hwdata_i[11:0];
      end
      if (wr_pend && wr_ofs == ILO_OFS_BSR) begin
        bsr_sh <= hwdata_i[3:0];
      end
      if (wr_pend && wr_ofs == ILO_OFS_INSTR) begin
        // Small field, bank bit clear, extension on: offset from the pointer.
        idx_sh <= ext_sh && !hwdata_i[8] && (fld <= ILO_IDX_MAX);
        if (ext_sh && !hwdata_i[8] && (fld <= ILO_IDX_MAX)) begin
          ea_sh <= sfp_sh + {4'h0, fld};
        end else if (!hwdata_i[8]) begin
          ea_sh <= (fld <= ILO_IDX_MAX) ? {4'h0, fld} : {ILO_ACC_HI_BNK, fld};
        end else begin
          ea_sh <= {bsr_sh, fld};
        end
      end
    end
  end

  // The effective address read back is the one the operand fields call for.
  a_eaddr_wrap: assert property (rd_tk && haddr_i[7:0] == ILO_OFS_EADDR
    |=> ##1 hrdata_o == {20'h0_0000, ea_sh})
    else $error("effective address differs from operand decode");
  a_status_bits: assert property (rd_tk && haddr_i[7:0] == ILO_OFS_STATUS
    |=> ##1 hrdata_o[31:10] == '0)
    else $error("status read has undefined bits set");
  // The indexed flag follows the bank bit, the field and the extension enable.
  a_status_index: assert property (rd_tk && haddr_i[7:0] == ILO_OFS_STATUS
    |=> ##1 hrdata_o[ILO_ST_IDX] == idx_sh)
    else $error("indexed flag differs from operand decode");
endmodule

// File: tb/tb.sv
// Self-checking bench of the indexed literal offset decoder.
`timescale 1ns/1ps
module tb;
  import ilo_pkg::*;
  logic        core_clk_i;
  logic        rst_n_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i;
  wire  logic  hready_i;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  int          bad_count;
  int          total_checks;
  int          cycles;
  // One slave, so its ready is the bus ready.
  assign hready_i = hreadyout_o;
  ilo_indexed_decode #(.ADDR_W(12)) dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
  );
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hang in any wait is cut short here and reported as a failure.
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Ready is sampled at the edge itself, before that edge's updates land.
  task automatic wait_rdy();
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
  endtask
  // One single word transfer: address phase held until ready, then data phase.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i  <= 32'(a);
    wait_rdy();
    hsel_i   <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wait_rdy();
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp, what);
  endtask
  // Load operands, run one add, then compare every visible effect.
  task automatic run_case(input logic ext, input logic [11:0] sfp, input logic [3:0] bank_select_register,
                          input logic [7:0] acc, input logic [7:0] mem,
                          input logic [15:0] op, input logic [11:0] ea, input logic idx);
    logic [8:0]  s;
    logic [4:0]  fl;
    logic [31:0] q;
    int          n;
    s  = {1'b0, acc} + {1'b0, mem};
    fl = {s[7], (acc[7] == mem[7]) && (s[7] != acc[7]), s[7:0] == 8'h00,
          ({1'b0, acc[3:0]} + {1'b0, mem[3:0]}) > 5'h0F, s[8]};
    wr(ILO_OFS_CTRL, 32'(ext));
    wr(ILO_OFS_SFP, 32'(sfp));
    wr(ILO_OFS_BSR, 32'(bank_select_register));
    wr(ILO_OFS_ACC, 32'(acc));
    wr(ILO_OFS_MADDR, 32'(ea));
    wr(ILO_OFS_MDATA, 32'(mem));
    wr(ILO_OFS_INSTR, 32'(op));
    xfer(1'b0, ILO_OFS_STATUS, 32'h0000_0000, q);
    chk(32'(q[ILO_ST_BSY]), 32'h0000_0001, "busy");
    n = 0;
    while (q[ILO_ST_BSY] !== 1'b0 && n < 8) begin
      xfer(1'b0, ILO_OFS_STATUS, 32'h0000_0000, q);
      n++;
    end
    chk(32'(q[ILO_ST_BSY]), 32'h0000_0000, "busy clear");
    chk(32'(n), 32'h0000_0001, "busy polls");
    rd(ILO_OFS_EADDR, 32'(ea), "eaddr");
    rd(ILO_OFS_STATUS, {22'h00_0000, idx, 4'h0, fl}, "status");
    rd(ILO_OFS_ACC, op[9] ? 32'(acc) : 32'(s[7:0]), "acc");
    rd(ILO_OFS_MDATA, op[9] ? 32'(s[7:0]) : 32'(mem), "mem");
  endtask
  initial begin
    rst_n_i  = 1'b0;
    hsel_i   = 1'b0;
    haddr_i  = 32'h0000_0000;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    hsize_i  = 3'b010;
    hwdata_i = 32'h0000_0000;
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(ILO_OFS_ACC, 32'h0000_0000, "acc reset");
    rd(ILO_OFS_STATUS, 32'h0000_0000, "status reset");
    wr(8'h30, 32'hFFFF_FFFF);
    rd(8'h30, 32'h0000_0000, "unmapped");
    run_case(1'b1, 12'hA00, 4'h0, 8'h17, 8'h20, 16'h242C, 12'hA2C, 1'b1);
    run_case(1'b1, 12'hA00, 4'h0, 8'h80, 8'h80, 16'h262C, 12'hA2C, 1'b1);
    run_case(1'b1, 12'hFF0, 4'h0, 8'h01, 8'h0F, 16'h245F, 12'h04F, 1'b1);
    run_case(1'b1, 12'hA00, 4'h0, 8'h05, 8'h06, 16'h2460, 12'hF60, 1'b0);
    run_case(1'b1, 12'hA00, 4'h3, 8'hF0, 8'h20, 16'h252C, 12'h32C, 1'b0);
    run_case(1'b0, 12'hA00, 4'h0, 8'h7F, 8'h01, 16'h242C, 12'h02C, 1'b0);
    run_case(1'b0, 12'hA00, 4'h5, 8'h11, 8'h22, 16'h2760, 12'h560, 1'b0);
    // An opcode other than the add still decodes its operand but changes nothing.
    wr(ILO_OFS_CTRL, 32'h0000_0001);
    wr(ILO_OFS_INSTR, 32'h0000_6A2C);
    repeat (4) @(posedge core_clk_i);
    rd(ILO_OFS_EADDR, 32'h0000_0A2C, "eaddr other");
    rd(ILO_OFS_STATUS, 32'h0000_0200, "status other");
    rd(ILO_OFS_ACC, 32'h0000_0011, "acc other");
    stop_test();
  end
endmodule
bind ilo_indexed_decode ilo_checker #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
);
